/* rpi_pkg.sv */
// Constants shared by the reduced-interface PHY-side block.
// Assumes a single 20 MHz core clock; the link reference is slower than it.
package rpi_pkg;

    // Core clock, period in nanoseconds (20 MHz)
    localparam int CLK_PERIOD_NS = 50;

    // Nominal interface reference in silicon, and the reduced rate used here
    localparam int LINK_REF_NOMINAL_MHZ = 50;
    localparam int SRC_25_MODE_MHZ      = 25;
    localparam int LINK_HALF_PERIOD_NS  = 200;

    // Half period of the generated reference in core cycles, rounded down, at least one
    localparam int LINK_HALF_RAW    = LINK_HALF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINK_HALF_CYCLES = (LINK_HALF_RAW < 1) ? 1 : LINK_HALF_RAW;
    localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYCLES - 1);

    // Reference periods a dibit is held at 10 Mbps
    localparam int         SLOW_HOLD_PERIODS = 10;
    localparam logic [3:0] SLOW_HOLD_LAST    = 4'(SLOW_HOLD_PERIODS - 1);

    // Carrier detect window at 100 Mbps, in line bits
    localparam int CARRIER_WINDOW_BITS = 10;

    // Data path widths and buffer depth
    localparam int DIBIT_W    = 2;
    localparam int FIFO_DEPTH = 16;

    // Idle dibit value on both directions
    localparam logic [1:0] DIBIT_IDLE = 2'h0;

    // Power-up clock mode: 0 = 25 MHz source mode, 1 = 50 MHz input mode
    localparam logic DEFAULT_MODE_50 = 1'b0;

    // Reset values
    localparam logic [3:0] CNT_RESET = 4'h0;

endpackage

/* rpi_fifo.sv */
// Small synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes both sides run on the single core clock.
`timescale 1ns/100ps
module rpi_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic [AW:0]      fill;
    wire              push;
    wire              pop;

    // Honest full and empty from the fill count
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_idx];

    // Storage written by index; contents need no reset
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wr_idx] <= in_data;
    end

    // Pointers and fill; wrap is natural since depth is a power of two
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_idx <= '0;
            rd_idx <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_idx <= wr_idx + 1'b1;
            if (pop)
                rd_idx <= rd_idx + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // rpi_fifo

/* rpi_link_clk.sv */
// Link reference handling: generates the reference in 25 MHz source mode,
// samples the external reference in 50 MHz input mode, flags rising edges.
// Assumes crystal_input is asynchronous to ref_clk and far slower than it.
`timescale 1ns/100ps
module rpi_link_clk (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic mode_50,
    input  wire logic crystal_input,
    output logic      ref_out,
    output logic      ref_out_oe,
    output logic      link_rise
);
    logic [3:0] div_cnt;
    logic       gen_clk;
    logic       xi_meta;
    logic       xi_sync;
    logic       xi_prev;
    wire        div_wrap;
    wire        gen_rise;
    wire        ext_rise;

    // Divider pulse and edge terms
    assign div_wrap = (div_cnt == rpi_pkg::LINK_HALF_LAST);
    assign gen_rise = div_wrap & ~gen_clk;
    assign ext_rise = xi_sync & ~xi_prev;

    // Source mode drives the reference; input mode leaves the pin undriven
    assign ref_out    = gen_clk;
    assign ref_out_oe = ~mode_50;
    assign link_rise  = mode_50 ? ext_rise : gen_rise;

    // Divider from the core clock, stands in for the synthesizer
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || mode_50)
        begin
            div_cnt <= rpi_pkg::CNT_RESET;
            gen_clk <= 1'b0;
        end
        else if (div_wrap)
        begin
            div_cnt <= rpi_pkg::CNT_RESET;
            gen_clk <= ~gen_clk;
        end
        else
            div_cnt <= div_cnt + 4'h1;
    end

    // Two-flop synchroniser, edge detect reads only the second stage
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            xi_meta <= 1'b0;
            xi_sync <= 1'b0;
            xi_prev <= 1'b0;
        end
        else
        begin
            xi_meta <= crystal_input;
            xi_sync <= xi_meta;
            xi_prev <= xi_sync;
        end
    end
endmodule // rpi_link_clk

/* rpi_top.sv */
// PHY-side reduced media interface: clock mode, transmit capture into a
// FIFO toward the copper transmit path, and receive delivery to the MAC.
// Assumes the copper paths run on ref_clk; MAC pins are asynchronous.
//
// Overview of operation
// - Reference clock times every interface signal; carrier sense here rises without waiting for a reference edge
// - 25 MHz mode drives generated reference out
// - 50 MHz mode takes reference on crystal input
// - All clocks derive from active mode source
// - Variant default mode, config bit flips it
// - Capture one transmit dibit per period, one per ten periods at 10 Mbps
// - Idle transmit dibit ignored when enable low
// - Carrier sense rises on detect, falls on loss
// - Carrier sense spans first to last dibit
// - Receive dibit zero until decoded data
// - One receive dibit per period, one per ten periods at 10 Mbps, clock synchronous
// - Receive dibit zero while carrier sense low
// - Receive error for at least one period
// - Both rates, both duplexes, independent directions
`timescale 1ns/100ps
module rpi_top (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       speed_100,
    input  wire logic       clock_mode_swap,
    input  wire logic       crystal_input,
    output logic            clock_mode_50,
    output logic            rmii_ref_clk_out,
    output logic            rmii_ref_clk_oe,
    input  wire logic       rmii_tx_en,
    input  wire logic [1:0] rmii_txd,
    output logic            rmii_crs_dv,
    output logic      [1:0] rmii_rxd,
    output logic            rmii_rx_er,
    output logic      [1:0] tx_dibit,
    output logic            tx_dibit_valid,
    input  wire logic       tx_dibit_ready,
    output logic            tx_active,
    output logic            tx_overrun,
    input  wire logic       rx_squelch_pass,
    input  wire logic       rx_line_bit,
    input  wire logic       rx_line_bit_valid,
    input  wire logic       rx_carrier_lost,
    input  wire logic [1:0] rx_dibit,
    input  wire logic       rx_dibit_valid,
    output logic            rx_dibit_ready,
    input  wire logic       rx_symbol_error
);
    ////////////////////////////////////////////////////////////////////////////
    // Carrier detect helper

    // True when two zeros with at least one bit between them lie in the window
    function automatic logic split_zeros(
        input logic [rpi_pkg::CARRIER_WINDOW_BITS-1:0] win
    );
        logic [rpi_pkg::CARRIER_WINDOW_BITS-1:0] z;
        logic                                    hit;
        z   = ~win;
        hit = 1'b0;
        for (int i = 0; i < rpi_pkg::CARRIER_WINDOW_BITS; i++)
            for (int j = i + 2; j < rpi_pkg::CARRIER_WINDOW_BITS; j++)
                if (z[i] && z[j])
                    hit = 1'b1;
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Clock mode and link reference

    logic link_rise;

    // Mode is the variant default, flipped by the configuration bit
    assign clock_mode_50 = rpi_pkg::DEFAULT_MODE_50 ^ clock_mode_swap;

    rpi_link_clk u_link (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .mode_50       (clock_mode_50),
        .crystal_input (crystal_input),
        .ref_out       (rmii_ref_clk_out),
        .ref_out_oe    (rmii_ref_clk_oe),
        .link_rise     (link_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit side

    logic       txen_meta;
    logic       txen_sync;
    logic [1:0] txd_meta;
    logic [1:0] txd_sync;
    logic [3:0] tx_cnt;
    wire        tx_slot;
    wire        tx_hold_last;
    wire        fifo_in_ready;

    // Pins from the MAC pass two flops before use
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            txen_meta <= 1'b0;
            txen_sync <= 1'b0;
            txd_meta  <= rpi_pkg::DIBIT_IDLE;
            txd_sync  <= rpi_pkg::DIBIT_IDLE;
        end
        else
        begin
            txen_meta <= rmii_tx_en;
            txen_sync <= txen_meta;
            txd_meta  <= rmii_txd;
            txd_sync  <= txd_meta;
        end
    end

    // Capture on the first period of each dibit; slow rate spaces by ten
    assign tx_hold_last = (tx_cnt == rpi_pkg::SLOW_HOLD_LAST);
    assign tx_slot = link_rise & txen_sync
                   & (speed_100 | (tx_cnt == rpi_pkg::CNT_RESET));

    // Period counter restarts with each frame, so the first dibit lines up
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tx_cnt <= rpi_pkg::CNT_RESET;
        else if (link_rise)
        begin
            if (!txen_sync || tx_hold_last || speed_100)
                tx_cnt <= rpi_pkg::CNT_RESET;
            else
                tx_cnt <= tx_cnt + 4'h1;
        end
    end

    // Data only enters while enable is high, idle dibits never reach the FIFO
    rpi_fifo #(
        .WIDTH (rpi_pkg::DIBIT_W),
        .DEPTH (rpi_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (txd_sync),
        .in_valid  (tx_slot),
        .in_ready  (fifo_in_ready),
        .out_data  (tx_dibit),
        .out_valid (tx_dibit_valid),
        .out_ready (tx_dibit_ready)
    );

    // MAC cannot be stalled, so a full FIFO drops the dibit and says so
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tx_active  <= 1'b0;
            tx_overrun <= 1'b0;
        end
        else
        begin
            tx_active  <= txen_sync;
            tx_overrun <= tx_slot & ~fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier detection

    logic [rpi_pkg::CARRIER_WINDOW_BITS-1:0] line_win;
    logic                                    carrier_fast;
    wire  [rpi_pkg::CARRIER_WINDOW_BITS-1:0] next_line_win;
    wire                                     fast_detect;
    wire                                     carrier;

    assign next_line_win = {line_win[rpi_pkg::CARRIER_WINDOW_BITS-2:0], rx_line_bit};
    assign fast_detect   = rx_line_bit_valid & split_zeros(next_line_win);
    assign carrier       = speed_100 ? carrier_fast : rx_squelch_pass;

    // Window idles at all ones; detect wins over a loss in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            line_win     <= '1;
            carrier_fast <= 1'b0;
        end
        else
        begin
            if (rx_line_bit_valid)
                line_win <= next_line_win;
            if (fast_detect)
                carrier_fast <= 1'b1;
            else if (rx_carrier_lost)
                carrier_fast <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive delivery

    logic [3:0] rx_cnt;
    logic       err_pend;
    wire        rx_slot;
    wire        rx_take;
    wire        next_crs_dv;

    // Each period, or each tenth at the slow rate, offers a delivery slot
    assign rx_slot = link_rise & rmii_crs_dv
                   & (speed_100 | (rx_cnt == rpi_pkg::SLOW_HOLD_LAST));
    assign rx_take = rx_slot & rx_dibit_valid;
    assign rx_dibit_ready = rx_slot;

    // Rise without waiting for a reference edge; fall only on an edge with
    // nothing left to deliver, so the last dibit still goes out
    assign next_crs_dv = carrier ? 1'b1
                       : ((link_rise && !rx_dibit_valid) ? 1'b0 : rmii_crs_dv);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rmii_crs_dv <= 1'b0;
        else
            rmii_crs_dv <= next_crs_dv;
    end

    // Slow-rate period counter for the receive direction
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !rmii_crs_dv)
            rx_cnt <= rpi_pkg::CNT_RESET;
        else if (link_rise)
            rx_cnt <= (rx_cnt == rpi_pkg::SLOW_HOLD_LAST || speed_100)
                    ? rpi_pkg::CNT_RESET : rx_cnt + 4'h1;
    end

    // Dibit changes only on reference edges; zero until decoded and when idle.
    // Cleared together with the fall of carrier sense, so no stale dibit shows
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !next_crs_dv)
            rmii_rxd <= rpi_pkg::DIBIT_IDLE;
        else if (rx_slot)
            rmii_rxd <= rx_take ? rx_dibit : rpi_pkg::DIBIT_IDLE;
    end

    // Error held pending until the next edge, then shown for a full period;
    // a new error in the clearing cycle stays pending
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            err_pend   <= 1'b0;
            rmii_rx_er <= 1'b0;
        end
        else
        begin
            if (rx_symbol_error)
                err_pend <= 1'b1;
            else if (link_rise)
                err_pend <= 1'b0;
            if (link_rise)
                rmii_rx_er <= err_pend | rx_symbol_error;
        end
    end

endmodule // rpi_top

/* rpi_top_props.sv */
// Port-level checker for the reduced-interface PHY block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module rpi_top_props (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       speed_100,
    input wire logic       clock_mode_swap,
    input wire logic       clock_mode_50,
    input wire logic       rmii_ref_clk_out,
    input wire logic       rmii_ref_clk_oe,
    input wire logic       rmii_crs_dv,
    input wire logic [1:0] rmii_rxd,
    input wire logic       rmii_rx_er,
    input wire logic       tx_overrun,
    input wire logic       rx_squelch_pass,
    input wire logic [1:0] rx_dibit,
    input wire logic       rx_dibit_valid,
    input wire logic       rx_dibit_ready,
    input wire logic       rx_symbol_error
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Clock mode and reference pin
    mode_select_a: assert property (
        clock_mode_50 == (rpi_pkg::DEFAULT_MODE_50 ^ clock_mode_swap))
        else $error("clock mode select wrong");
    ref_drive_a: assert property (rmii_ref_clk_oe == !clock_mode_50)
        else $error("reference drive enable wrong");
    // Generated reference: 4 high, 4 low, never a short half
    ref_period_a: assert property (
        !clock_mode_50 && $rose(rmii_ref_clk_out)
        |-> rmii_ref_clk_out [*4] ##1 !rmii_ref_clk_out [*4] ##1 rmii_ref_clk_out)
        else $error("reference period wrong");
    ////////////////////////////////////////////////////////////////////////////////
    // Receive side, then the transmit overrun flag
    crs_rise_a: assert property (rx_squelch_pass && !speed_100 |=> rmii_crs_dv)
        else $error("carrier sense late");
    rxd_idle_a: assert property (!rmii_crs_dv |-> rmii_rxd == rpi_pkg::DIBIT_IDLE)
        else $error("receive dibit not idle");
    rx_slot_a: assert property (
        rx_dibit_ready && rx_dibit_valid |=> rmii_rxd == $past(rx_dibit))
        else $error("receive dibit not delivered");
    rxd_hold_a: assert property (
        rmii_crs_dv && !rx_dibit_ready |=> rmii_rxd == $past(rmii_rxd) || !rmii_crs_dv)
        else $error("receive dibit moved off slot");
    // Error flag: raised by the next reference edge, held a full period
    err_raise_a: assert property (
        !clock_mode_50 && rx_symbol_error |-> ##[1:10] rmii_rx_er)
        else $error("receive error missing");
    err_hold_a: assert property (
        !clock_mode_50 && $rose(rmii_rx_er) |-> rmii_rx_er [*8])
        else $error("receive error too short");
    overrun_pulse_a: assert property (tx_overrun |=> !tx_overrun)
        else $error("overrun flag stuck");
endmodule // rpi_top_props

bind rpi_top rpi_top_props chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .speed_100(speed_100),
    .clock_mode_swap(clock_mode_swap), .clock_mode_50(clock_mode_50),
    .rmii_ref_clk_out(rmii_ref_clk_out), .rmii_ref_clk_oe(rmii_ref_clk_oe),
    .rmii_crs_dv(rmii_crs_dv), .rmii_rxd(rmii_rxd), .rmii_rx_er(rmii_rx_er),
    .tx_overrun(tx_overrun), .rx_squelch_pass(rx_squelch_pass), .rx_dibit(rx_dibit),
    .rx_dibit_valid(rx_dibit_valid), .rx_dibit_ready(rx_dibit_ready),
    .rx_symbol_error(rx_symbol_error));

/* rpi_mac_model.sv */
// MAC-side partner: frames transmit enable and dibits on its reference.
// Assumes link_ref is whichever reference the active clock mode uses.
`timescale 1ns/100ps
module rpi_mac_model (
    input wire logic       link_ref,
    input wire logic       start,
    input wire logic       speed_100,
    input wire logic       idle_junk,
    input wire logic [1:0] base,
    input wire logic [5:0] len,
    output logic           tx_en,
    output logic     [1:0] txd,
    output logic           busy
);
    logic [5:0] left = 6'h00;
    logic [3:0] hold = 4'h0;
    // Slow rate repeats each dibit; junk idle tests the device's filter
    wire  [3:0] hold_last = speed_100 ? 4'h0 : 4'h9;
    wire  [1:0] idle_val  = idle_junk ? 2'h3 : 2'h0;
    initial
    begin
        tx_en = 1'b0;
        txd   = 2'h0;
        busy  = 1'b0;
    end
    // Frame sequencer on the MAC's own reference edge
    always @(posedge link_ref)
    begin
        if (!busy)
        begin
            tx_en <= start;
            txd   <= start ? base : idle_val;
            busy  <= start;
            left  <= len;
            hold  <= 4'h0;
        end
        else if (hold != hold_last)
            hold <= hold + 4'h1;
        else if (left == 6'h01)
        begin
            tx_en <= 1'b0;
            txd   <= idle_val;
            busy  <= 1'b0;
        end
        else
        begin
            txd  <= txd + 2'h1;
            left <= left - 6'h01;
            hold <= 4'h0;
        end
    end
endmodule // rpi_mac_model

/* rpi_top_bench.sv */
// Self-checking bench for the reduced-interface PHY block and a MAC model.
// Assumes a 20 MHz core clock and a free-running 400 ns external reference.
`timescale 1ns/100ps
module rpi_top_bench;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       speed_100 = 1'b1, swap = 1'b0, xtal = 1'b0, tx_rdy = 1'b0;
    logic       sq = 1'b0, lb = 1'b0, lbv = 1'b0, lost = 1'b0, rxv = 1'b0;
    logic       serr = 1'b0, start = 1'b0, junk = 1'b0;
    logic [1:0] rxdi = 2'h0, base = 2'h0;
    logic [5:0] len = 6'h01;
    logic       tx_en, tx_v, ovr, crs_dv, rx_er, rxr, mode50, ref_o, ref_oe, busy;
    logic [1:0] txd, tx_d, rxd;
    logic [1:0] got[$];
    int         bad_count = 0, checks_done = 0, ovr_cnt = 0, cyc = 0, k;
    wire        link = mode50 ? xtal : ref_o;

    always #25 ref_clk = ~ref_clk;
    // Outside reference, phase unrelated to the core clock
    initial
    begin
        #13;
        forever #200 xtal = ~xtal;
    end

    rpi_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .speed_100(speed_100),
        .clock_mode_swap(swap), .crystal_input(xtal), .clock_mode_50(mode50),
        .rmii_ref_clk_out(ref_o), .rmii_ref_clk_oe(ref_oe), .rmii_tx_en(tx_en),
        .rmii_txd(txd), .rmii_crs_dv(crs_dv), .rmii_rxd(rxd), .rmii_rx_er(rx_er),
        .tx_dibit(tx_d), .tx_dibit_valid(tx_v), .tx_dibit_ready(tx_rdy),
        .tx_active(), .tx_overrun(ovr), .rx_squelch_pass(sq), .rx_line_bit(lb),
        .rx_line_bit_valid(lbv), .rx_carrier_lost(lost), .rx_dibit(rxdi),
        .rx_dibit_valid(rxv), .rx_dibit_ready(rxr), .rx_symbol_error(serr));
    rpi_mac_model mac_u (.link_ref(link), .start(start), .speed_100(speed_100),
        .idle_junk(junk), .base(base), .len(len), .tx_en(tx_en), .txd(txd), .busy(busy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Sink of the copper side, overrun tally, hang ceiling
    always @(posedge ref_clk)
    begin
        if (tx_v === 1'b1 && tx_rdy === 1'b1)
            got.push_back(tx_d);
        if (ovr === 1'b1)
            ovr_cnt++;
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic restart(input logic s);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        swap  <= s;
        tick(2);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(4);
        chk(mode50 === (rpi_pkg::DEFAULT_MODE_50 ^ s), "clock mode");
        chk(ref_oe === ~mode50, "reference drive");
    endtask
    // Whole frame from the MAC; waits for its end plus sync lag
    task automatic send(input logic [1:0] b, input logic [5:0] n);
        @(posedge ref_clk);
        base  <= b;
        len   <= n;
        start <= 1'b1;
        for (k = 0; k < 40 && busy !== 1'b1; k++)
            tick(1);
        @(posedge ref_clk);
        start <= 1'b0;
        for (k = 0; k < 1000 && busy === 1'b1; k++)
            tick(1);
        tick(12);
    endtask
    task automatic check_tx(input logic [1:0] b, input int n);
        chk(got.size() == n, "tx dibit count");
        for (int i = 0; i < n; i++)
            chk(got.size() > i && got[i] === b + 2'(i), "tx dibit value");
    endtask
    task automatic lbit(input logic b);
        @(posedge ref_clk);
        lb  <= b;
        lbv <= 1'b1;
        @(posedge ref_clk);
        lbv <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Fast frame in either mode, junk on idle pins first
    task automatic t_fast(input logic s);
        restart(s);
        got.delete();
        @(posedge ref_clk);
        speed_100 <= 1'b1;
        tx_rdy    <= 1'b1;
        junk      <= 1'b1;
        tick(40);
        chk(got.size() == 0 && tx_v === 1'b0, "idle dibit taken");
        send(2'h1, 6'h06);
        check_tx(2'h1, 6);
    endtask
    task automatic t_slow();
        @(posedge ref_clk);
        speed_100 <= 1'b0;
        junk      <= 1'b0;
        tick(1);
        got.delete();
        send(2'h2, 6'h03);
        check_tx(2'h2, 3);
    endtask
    // Stalled copper side: buffer fills, extra dibits dropped
    task automatic t_ovr();
        @(posedge ref_clk);
        speed_100 <= 1'b1;
        tx_rdy    <= 1'b0;
        tick(1);
        got.delete();
        ovr_cnt = 0;
        send(2'h0, 6'h14);
        chk(ovr_cnt == 20 - rpi_pkg::FIFO_DEPTH, "overrun count");
        @(posedge ref_clk);
        tx_rdy <= 1'b1;
        tick(24);
        check_tx(2'h0, rpi_pkg::FIFO_DEPTH);
    endtask
    task automatic t_rx10();
        @(posedge ref_clk);
        speed_100 <= 1'b0;
        rxv       <= 1'b1;
        rxdi      <= 2'h2;
        sq        <= 1'b1;
        tick(1);
        chk(crs_dv === 1'b1 && rxd === 2'h0, "carrier rise");
        chk((tx_en & crs_dv) === 1'b0, "false collision");
        for (k = 0; k < 100 && rxr !== 1'b1; k++)
            tick(1);
        chk(k > 60 && k < 100, "first slot spacing");
        tick(1);
        chk(rxd === 2'h2, "rx dibit");
        @(posedge ref_clk);
        serr <= 1'b1;
        @(posedge ref_clk);
        serr <= 1'b0;
        for (k = 0; k < 12 && rx_er !== 1'b1; k++)
            tick(1);
        chk(rx_er === 1'b1, "rx error");
        @(posedge ref_clk);
        sq  <= 1'b0;
        rxv <= 1'b0;
        for (k = 0; k < 20 && crs_dv !== 1'b0; k++)
            tick(1);
        chk(crs_dv === 1'b0 && rxd === 2'h0, "carrier fall");
    endtask
    task automatic t_rx100();
        @(posedge ref_clk);
        speed_100 <= 1'b1;
        lbit(1'b0);
        lbit(1'b0);
        tick(3);
        chk(crs_dv === 1'b0, "adjacent zeros");
        lbit(1'b1);
        lbit(1'b0);
        tick(3);
        chk(crs_dv === 1'b1, "split zeros");
        for (int i = 0; i < 10; i++)
            lbit(1'b1);
        @(posedge ref_clk);
        lost <= 1'b1;
        @(posedge ref_clk);
        lost <= 1'b0;
        tick(20);
        chk(crs_dv === 1'b0 && rxd === 2'h0, "carrier lost");
        chk(crs_dv === 1'b1 || rx_er === 1'b0, "error outside frame");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        t_fast(1'b0);
        t_slow();
        t_ovr();
        t_rx10();
        t_rx100();
        t_fast(1'b1);
        report_and_stop();
    end
endmodule // rpi_top_bench
